// ### common/spiep_params.svh
// spiep_params.svh: constants of the serial eeprom command front end
// assumes: included by bare name from rtl and bench files
`ifndef SPIEP_PARAMS_SVH
`define SPIEP_PARAMS_SVH
`define SPIEP_OP_SET_LATCH 8'h06
`define SPIEP_OP_CLR_LATCH 8'h04
`define SPIEP_OP_STAT_RD 8'h05
`define SPIEP_OP_STAT_WR 8'h01
`define SPIEP_OP_ARR_RD 8'h03
`define SPIEP_OP_ARR_WR 8'h02
`define SPIEP_OP_MASK 8'hf7
`define SPIEP_OP_ADDR_BIT 3
`define SPIEP_ST_BUSY 0
`define SPIEP_ST_LATCH 1
`define SPIEP_ST_PLO 2
`define SPIEP_ST_PHI 3
`define SPIEP_ST_ONES 4'hf
`define SPIEP_PROT_RESET 2'h0
`define SPIEP_PROT_QUART 9'h0c0
`define SPIEP_PROT_HALF 9'h080
`define SPIEP_PAGE_BYTES 16
`define SPIEP_WRITE_TIME_NS 10000000
`define SPIEP_CLK_NS 4
`define SPIEP_WRITE_CYCLES (`SPIEP_WRITE_TIME_NS / `SPIEP_CLK_NS)
`define SPIEP_FIFO_DEPTH 8
`endif

// ### common/spiep_pkg.sv
// spiep_pkg: types of the serial eeprom command front end
// assumes: constants come from spiep_params.svh
package spiep_pkg;
  typedef enum logic [2:0] {
    SPIEP_IDLE = 3'h0,
    SPIEP_OPCODE = 3'h1,
    SPIEP_ADDR = 3'h3,
    SPIEP_DATA = 3'h2,
    SPIEP_STATUS = 3'h6,
    SPIEP_WAIT = 3'h7
  } spiep_state_type;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } spiep_word_type;
endpackage : spiep_pkg

// ### rtl/spiep_core.sv
// spiep_core: serial slave front end of a 512 byte eeprom
// assumes: pins are asynchronous to sys_clk and sampled twice; array on ports
`timescale 1ns/1ps
`include "spiep_params.svh"
module spiep_core #(
  parameter int WRITE_CYCLES = `SPIEP_WRITE_CYCLES,
  parameter int FIFO_DEPTH = `SPIEP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic hold_n,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serial_out_oe,
  // array port
  output logic [8:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_en,
  output logic [8:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  // state
  output logic standby,
  output logic [7:0] protect_status
);
  // ==========================================
  // pin synchronisers
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_d;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1 <= 5'h1e;
      pin_s2 <= 5'h1e;
      pin_d <= 5'h1e;
    end else begin
      pin_s1 <= {write_protect_n, hold_n, select_n, serial_in, serial_clk} ^ 5'h00;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end
  logic sclk;
  logic sel_n;
  logic sdi;
  logic hold_i;
  logic wp_n;
  assign {wp_n, hold_i, sel_n, sdi, sclk} = pin_s2;
  logic sclk_fall;
  logic sclk_rise;
  logic sel_fall;
  logic sel_rise;
  logic hold_fall;
  logic hold_rise;
  assign sclk_fall = pin_d[0] && !sclk;
  assign sclk_rise = !pin_d[0] && sclk;
  assign sel_fall = pin_d[2] && !sel_n;
  assign sel_rise = !pin_d[2] && sel_n;
  assign hold_fall = pin_d[3] && !hold_i;
  assign hold_rise = !pin_d[3] && hold_i;
  // ==========================================
  // pause and framing
  logic armed;
  logic paused;
  logic active;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      armed <= 1'b0;
    end else if (sel_fall) begin
      armed <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      paused <= 1'b0;
    end else if (!sel_n && !sclk && hold_fall) begin
      paused <= 1'b1;
    end else if (!sel_n && !sclk && hold_rise) begin
      paused <= 1'b0;
    end
  end
  assign active = armed && !sel_n && !paused;
  // ==========================================
  // shifting and decode
  spiep_pkg::spiep_state_type state;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] opcode;
  logic [8:0] addr;
  logic [7:0] shift_out;
  logic [7:0] status_new;
  logic byte_done;
  logic wr_latch;
  logic busy;
  logic busy_status;
  logic [1:0] prot;
  logic [7:0] rx_byte;
  logic [7:0] op_masked;
  logic last_bit;
  logic wr_ok_boundary;
  assign rx_byte = {shift_in[6:0], sdi};
  assign last_bit = (bit_cnt == 3'h7);
  assign op_masked = rx_byte & `SPIEP_OP_MASK;
  assign protect_status = {`SPIEP_ST_ONES, prot, wr_latch, busy};
  always_ff @(posedge sys_clk) begin
    if (sys_rst || sel_n || paused && !sel_n && sel_fall) begin
      state <= spiep_pkg::SPIEP_OPCODE;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      wr_ok_boundary <= 1'b0;
    end else if (active && sclk_fall) begin
      shift_in <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
      wr_ok_boundary <= 1'b0;
      if (last_bit) begin
        case (state)
          spiep_pkg::SPIEP_OPCODE: begin
            opcode <= rx_byte;
            addr[8] <= rx_byte[`SPIEP_OP_ADDR_BIT];
            if (op_masked == `SPIEP_OP_STAT_RD) begin
              state <= spiep_pkg::SPIEP_STATUS;
            end else if (op_masked == `SPIEP_OP_STAT_WR) begin
              state <= spiep_pkg::SPIEP_DATA;
            end else if (op_masked == `SPIEP_OP_ARR_RD && !busy
                || op_masked == `SPIEP_OP_ARR_WR && !busy) begin
              state <= spiep_pkg::SPIEP_ADDR;
            end else begin
              state <= spiep_pkg::SPIEP_WAIT;
            end
          end
          spiep_pkg::SPIEP_ADDR: begin
            addr[7:0] <= rx_byte;
            state <= spiep_pkg::SPIEP_DATA;
          end
          spiep_pkg::SPIEP_DATA: begin
            if ((opcode & `SPIEP_OP_MASK) == `SPIEP_OP_STAT_WR) begin
              status_new <= rx_byte;
              wr_ok_boundary <= !byte_done;
              byte_done <= 1'b1;
            end else if ((opcode & `SPIEP_OP_MASK) == `SPIEP_OP_ARR_WR) begin
              addr[3:0] <= addr[3:0] + 4'h1;
              wr_ok_boundary <= 1'b1;
            end else begin
              addr <= addr + 9'h001;
            end
          end
          spiep_pkg::SPIEP_STATUS: begin
            state <= spiep_pkg::SPIEP_WAIT;
          end
          default: begin
            state <= spiep_pkg::SPIEP_WAIT;
          end
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_out <= 8'hff;
    end else if (active && sclk_rise) begin
      if (bit_cnt == 3'h0 && state == spiep_pkg::SPIEP_STATUS) begin
        shift_out <= protect_status;
      end else if (bit_cnt == 3'h0 && state == spiep_pkg::SPIEP_DATA
          && (opcode & `SPIEP_OP_MASK) == `SPIEP_OP_ARR_RD) begin
        shift_out <= mem_rd_data;
      end else begin
        shift_out <= {shift_out[6:0], 1'b1};
      end
    end
  end
  assign mem_rd_addr = addr;
  assign serial_out = shift_out[7];
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !active || state == spiep_pkg::SPIEP_WAIT) begin
      serial_out_oe <= 1'b0;
    end else if (sclk_rise) begin
      serial_out_oe <= state == spiep_pkg::SPIEP_STATUS
        || state == spiep_pkg::SPIEP_DATA && (opcode & `SPIEP_OP_MASK) == `SPIEP_OP_ARR_RD;
    end
  end
  // ==========================================
  // page buffer
  spiep_pkg::spiep_word_type fifo_in;
  spiep_pkg::spiep_word_type fifo_out;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic prog_go;
  logic fifo_flush;
  assign fifo_in.addr = addr;
  assign fifo_in.data = rx_byte;
  // page bytes collected, backpressure drops overflow
  assign fifo_push = active && sclk_fall && last_bit && state == spiep_pkg::SPIEP_DATA
    && (opcode & `SPIEP_OP_MASK) == `SPIEP_OP_ARR_WR;
  assign fifo_pop = prog_go && busy && !busy_status;
  assign fifo_flush = sel_fall && !busy;
  spiep_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );
  assign mem_wr_en = fifo_pop && fifo_valid;
  assign mem_wr_addr = fifo_out.addr;
  assign mem_wr_data = fifo_out.data;
  // ==========================================
  // protection and programming trigger
  logic blocked;
  logic start_arr;
  logic start_stat;
  logic [31:0] wr_timer;
  // protected range, same map in both halves
  always_comb begin
    case (prot)
      2'h0: blocked = 1'b0;
      2'h1: blocked = {1'b0, addr[7:0]} >= `SPIEP_PROT_QUART;
      2'h2: blocked = {1'b0, addr[7:0]} >= `SPIEP_PROT_HALF;
      default: blocked = 1'b1;
    endcase
  end
  assign start_arr = sel_rise && wr_ok_boundary && bit_cnt == 3'h0 && wr_latch && wp_n
    && !blocked && (opcode & `SPIEP_OP_MASK) == `SPIEP_OP_ARR_WR && !busy && !paused;
  assign start_stat = sel_rise && wr_ok_boundary && bit_cnt == 3'h0 && wr_latch && wp_n
    && (opcode & `SPIEP_OP_MASK) == `SPIEP_OP_STAT_WR && !busy && !paused;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      busy_status <= 1'b0;
      prog_go <= 1'b0;
      wr_timer <= '0;
    end else if (start_arr || start_stat) begin
      busy <= 1'b1;
      busy_status <= start_stat;
      prog_go <= start_arr;
      wr_timer <= 32'(WRITE_CYCLES);
    end else if (busy) begin
      wr_timer <= wr_timer - 32'h1;
      if (wr_timer == 32'h1) begin
        busy <= 1'b0;
        busy_status <= 1'b0;
        prog_go <= 1'b0;
      end
    end
  end
  // protect bits change at end of status cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prot <= `SPIEP_PROT_RESET;
    end else if (busy_status && wr_timer == 32'h1) begin
      prot <= status_new[`SPIEP_ST_PHI:`SPIEP_ST_PLO];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !wp_n) begin
      wr_latch <= 1'b0;
    end else if (start_arr || start_stat) begin
      wr_latch <= 1'b0;
    end else if (active && sclk_fall && last_bit && state == spiep_pkg::SPIEP_OPCODE) begin
      if (op_masked == `SPIEP_OP_SET_LATCH) begin
        wr_latch <= 1'b1;
      end else if (op_masked == `SPIEP_OP_CLR_LATCH) begin
        wr_latch <= 1'b0;
      end
    end
  end
  assign standby = sel_n && !busy;
  // ==========================================
  // checks
  property p_oe_off_deselect;
    @(posedge sys_clk) disable iff (sys_rst)
    sel_n |=> !serial_out_oe;
  endproperty
  a_oe_off_deselect: assert property (p_oe_off_deselect) else $error("output driven deselected");
  property p_wp_clears;
    @(posedge sys_clk) disable iff (sys_rst)
    !wp_n |=> !wr_latch;
  endproperty
  a_wp_clears: assert property (p_wp_clears) else $error("latch kept under protect");
  property p_busy_holds;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(busy) |-> busy[*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("cycle aborted");
  property p_no_start_wp;
    @(posedge sys_clk) disable iff (sys_rst)
    !wp_n |=> !$rose(busy);
  endproperty
  a_no_start_wp: assert property (p_no_start_wp) else $error("programming under protect");
  property p_status_layout;
    @(posedge sys_clk) disable iff (sys_rst)
    protect_status[7:4] == 4'hf && protect_status[0] == busy;
  endproperty
  a_status_layout: assert property (p_status_layout) else $error("bad status layout");
  property p_latch_consumed;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(busy) |-> !wr_latch;
  endproperty
  a_latch_consumed: assert property (p_latch_consumed) else $error("latch not cleared");
  property p_old_prot;
    @(posedge sys_clk) disable iff (sys_rst)
    busy_status && wr_timer > 32'h1 |=> $stable(prot);
  endproperty
  a_old_prot: assert property (p_old_prot) else $error("protect changed early");
  property p_wait_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
    state == spiep_pkg::SPIEP_WAIT && !sel_n |=> !serial_out_oe;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("output in wait");
endmodule : spiep_core

// ### rtl/spiep_fifo.sv
// spiep_fifo: small valid/ready fifo for page data words
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
module spiep_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  // honest full and empty flags
  assign count = wr_ptr - rd_ptr;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];
  // storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  // pointer update
  always_ff @(posedge sys_clk) begin
    if (sys_rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : spiep_fifo

// ### tb/spi_eeprom_command_protect_tb_top.sv
// spi_eeprom_command_protect_tb_top: self-checking bench of spiep_core
// assumes: master model drives pins, bench models the array read port
`timescale 1ns/1ps
`include "spiep_params.svh"
module spi_eeprom_command_protect_tb_top;
  localparam int WCYC = 2000;
  logic sys_clk, sys_rst, write_protect_n, tgl, so_line, rx_stb;
  logic serial_clk, select_n, serial_in, hold_n, serial_out, serial_out_oe;
  logic mem_wr_en, standby;
  logic [8:0] mem_rd_addr, mem_wr_addr;
  logic [7:0] mem_rd_data, mem_wr_data, protect_status, rx_byte;
  logic [15:0] rd_e;
  logic [16:0] wr_e;
  logic [15:0] rd_q[$]; // mask and expected byte
  logic [16:0] wr_q[$]; // address and data
  int fail_count, num_checks, seed;

  // ==========================================
  // instances
  spiep_core #(.WRITE_CYCLES(WCYC), .FIFO_DEPTH(8)) spiep_core_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .select_n(select_n), .serial_in(serial_in), .hold_n(hold_n),
    .write_protect_n(write_protect_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .standby(standby), .protect_status(protect_status));
  spiep_master_model spiep_master_model_i (
    .sys_clk(sys_clk), .serial_clk(serial_clk), .select_n(select_n),
    .serial_in(serial_in), .hold_n(hold_n), .so_line(so_line),
    .rx_stb(rx_stb), .rx_byte(rx_byte));

  // array contents seen by reads
  function automatic logic [7:0] arr_val(input logic [8:0] a);
    return a[7:0] ^ {a[8], 7'h2b};
  endfunction : arr_val
  assign mem_rd_data = arr_val(mem_rd_addr);
  // released output shows a changing pattern
  assign so_line = serial_out_oe ? serial_out : tgl;

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) tgl <= (tgl === 1'b1) ? 1'b0 : 1'b1;

  // ==========================================
  // checking
  task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // serial read results against oldest note
  always @(posedge sys_clk) begin
    if (rx_stb === 1'b1) begin
      rd_e = rd_q.size() > 0 ? rd_q.pop_front() : 16'hffff;
      check("rx_byte", {9'h0, rd_e[7:0]}, {9'h0, rx_byte & rd_e[15:8]});
    end
    if (mem_wr_en === 1'b1) begin
      wr_e = wr_q.size() > 0 ? wr_q.pop_front() : 17'h1ffff;
      check("mem_write", wr_e, {mem_wr_addr, mem_wr_data});
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // ==========================================
  // frame helpers
  task automatic frame(input logic [23:0] b, input int n);
    spiep_master_model_i.frame_open();
    for (int i = 0; i < n; i++) spiep_master_model_i.xfer(b[23-8*i -: 8], 1'b0);
    spiep_master_model_i.frame_close();
  endtask : frame

  task automatic stat_rd(input logic [7:0] exp, input logic [7:0] mask);
    rd_q.push_back({mask, exp & mask});
    spiep_master_model_i.frame_open();
    spiep_master_model_i.xfer(`SPIEP_OP_STAT_RD, 1'b0);
    spiep_master_model_i.xfer(8'h00, 1'b1);
    #100;
    check("oe_after_status", 17'h0, {16'h0, serial_out_oe});
    spiep_master_model_i.frame_close();
  endtask : stat_rd

  // latch set before each array write
  task automatic arr_wr(input logic [8:0] a, input int n, input bit ok);
    logic [7:0] d;
    frame(24'h060000, 1);
    spiep_master_model_i.frame_open();
    spiep_master_model_i.xfer(`SPIEP_OP_ARR_WR | {4'h0, a[8], 3'h0}, 1'b0);
    spiep_master_model_i.xfer(a[7:0], 1'b0);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (ok) wr_q.push_back({a[8:4], a[3:0] + 4'(i), d});
      spiep_master_model_i.xfer(d, 1'b0);
    end
    spiep_master_model_i.frame_close();
  endtask : arr_wr

  task automatic wait_idle();
    int n;
    n = 0;
    while (protect_status[`SPIEP_ST_BUSY] !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    check("busy_end", 17'h0, {16'h0, protect_status[`SPIEP_ST_BUSY]});
  endtask : wait_idle

  // ==========================================
  // watchdog
  initial begin
    #300000;
    fail_count++;
    $display("ERROR watchdog expected end seen timeout");
    give_verdict();
  end

  // ==========================================
  // main sequence
  initial begin
    seed = 32'h0599;
    fail_count = 0;
    num_checks = 0;
    write_protect_n = 1'b1;
    sys_rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    check("status_reset", 17'h0f0, {9'h0, protect_status});
    check("standby", 17'h1, {16'h0, standby});
    $display("test reset done");
    frame(24'h0e0000, 1);
    stat_rd(8'hf2, 8'hff);
    frame(24'h040000, 1);
    stat_rd(8'hf0, 8'hff);
    frame(24'h060400, 2);
    stat_rd(8'hf2, 8'hff);
    frame(24'h040600, 2);
    stat_rd(8'hf0, 8'hff);
    $display("test latch done");
    spiep_master_model_i.frame_open();
    spiep_master_model_i.xfer(8'h07, 1'b0);
    spiep_master_model_i.xfer(8'h00, 1'b0);
    check("oe_unknown_op", 17'h0, {16'h0, serial_out_oe});
    spiep_master_model_i.frame_close();
    frame(24'h070600, 2);
    stat_rd(8'hf0, 8'hff);
    $display("test unknown opcode done");
    frame(24'h060000, 1);
    frame(24'h010400, 2);
    check("status_old_bits", 17'h0f1, {9'h0, protect_status & 8'hfd});
    check("standby_busy", 17'h0, {16'h0, standby});
    stat_rd(8'hf1, 8'hff);
    wait_idle();
    stat_rd(8'hf4, 8'hff);
    frame(24'h060000, 1);
    frame(24'h010c00, 3);
    repeat (20) @(posedge sys_clk);
    stat_rd(8'hf6, 8'hff);
    $display("test status write done");
    arr_wr(9'h11e, 3, 1'b1);
    spiep_master_model_i.frame_open();
    spiep_master_model_i.xfer(`SPIEP_OP_ARR_RD, 1'b0);
    spiep_master_model_i.xfer(8'h00, 1'b0);
    spiep_master_model_i.xfer(8'h00, 1'b0);
    check("oe_read_busy", 17'h0, {16'h0, serial_out_oe});
    spiep_master_model_i.frame_close();
    wait_idle();
    stat_rd(8'hf4, 8'hff);
    arr_wr(9'h0c4, 1, 1'b0);
    wait_idle();
    @(posedge sys_clk);
    #1 write_protect_n = 1'b0;
    arr_wr(9'h010, 1, 1'b0);
    stat_rd(8'hf4, 8'hff);
    @(posedge sys_clk);
    #1 write_protect_n = 1'b1;
    $display("test array write done");
    rd_q.push_back({8'hff, arr_val(9'h1ff)});
    rd_q.push_back({8'hff, arr_val(9'h000)});
    spiep_master_model_i.frame_open();
    spiep_master_model_i.xfer(`SPIEP_OP_ARR_RD | 8'h08, 1'b0);
    spiep_master_model_i.xfer(8'hff, 1'b0);
    spiep_master_model_i.xfer(8'h00, 1'b1);
    fork
      spiep_master_model_i.pause(500);
      #300 check("oe_paused", 17'h0, {16'h0, serial_out_oe});
    join
    spiep_master_model_i.xfer(8'h00, 1'b1);
    spiep_master_model_i.frame_close();
    $display("test array read done");
    repeat (10) @(posedge sys_clk);
    check("notes_left", 17'h0, 17'(rd_q.size() + wr_q.size()));
    give_verdict();
  end
endmodule : spi_eeprom_command_protect_tb_top

// ### tb/spiep_master_model.sv
// spiep_master_model: far-side spi master, clock mode (0,1), idle low
// assumes: serial pins are asynchronous to sys_clk; sys_clk paces the strobe
`timescale 1ns/1ps
module spiep_master_model (
  // clock
  input wire logic sys_clk,
  // serial pins
  output logic serial_clk,
  output logic select_n,
  output logic serial_in,
  output logic hold_n,
  input wire logic so_line,
  // received byte
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  // ==========================================
  // pin idle levels
  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
    hold_n = 1'b1;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end

  // select falls to open a frame
  task automatic frame_open();
    select_n = 1'b0;
    #100;
  endtask : frame_open

  // select rises just after last byte
  task automatic frame_close();
    #60;
    select_n = 1'b1;
    serial_in = ~serial_in; // released line drops its last value
    #300;
  endtask : frame_close

  // msb first, data set for falling edge
  task automatic xfer(input logic [7:0] tx, input bit chk);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      #20 serial_in = tx[i];
      #42.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
      rx[i] = so_line;
    end
    if (chk) begin
      rx_byte = rx;
      rx_stb = 1'b1;
      @(posedge sys_clk);
      #1 rx_stb = 1'b0;
    end
  endtask : xfer

  // pause edges only while clock is low
  task automatic pause(input int ns);
    hold_n = 1'b0;
    #ns;
    hold_n = 1'b1;
    #100;
  endtask : pause
endmodule : spiep_master_model
